// [logic/ebwsu_top.sv]
`timescale 1ns/1ps
module ebwsu_top
	import ebwsu_pkg::*;
(
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic [19:0] cpu_addr,
	input wire logic cpu_on_chip,
	input wire logic int_mem_read_n,
	input wire logic int_mem_write_n,
	input wire logic int_io_read_n,
	input wire logic int_io_write_n,
	input wire logic ext_wait_request,
	input wire logic [1:0] system_control_1_wait,
	input wire logic cs17_enable,
	input wire logic cs18_enable,
	input wire logic [1:0] mode_sel,
	input wire logic debug_serial_pin_in,
	output logic debug_serial_pin_out,
	output logic debug_serial_pin_oe,
	output logic debug_monitor_start,
	output logic [16:0] ext_addr,
	output logic rom_select_n,
	output logic ram_rom_select_n,
	output logic ext_mem_read_n,
	output logic ext_mem_write_n,
	output logic ext_io_read_n,
	output logic ext_io_write_n,
	output logic cpu_wait,
	output logic clk_out
);

	typedef struct packed {
		ebwsu_state_e state;
		ebwsu_kind_e kind;
		logic [1:0] wait_cnt;
		logic zero_wait;
		logic [16:0] addr_out;
		logic pin17;
		logic pin18;
		logic mem_rd_n;
		logic mem_wr_n;
		logic io_rd_n;
		logic io_wr_n;
		logic cpu_wait;
		logic clk_out;
		logic strap_pending;
		logic debug_start;
		logic dbg_out;
		logic dbg_oe;
	} ebwsu_top_s;

	ebwsu_top_s st_r;
	ebwsu_top_s st_nxt;

	ebwsu_if link ();

	ebwsu_clkdiv u_div (
		.mclk(mclk),
		.arst_n(arst_n),
		.bus(link.div)
	);

	ebwsu_decode u_dec (
		.bus(link.dec)
	);

	assign link.addr = cpu_addr;

	logic any_req;
	logic ext_req;
	logic is_mem;
	logic [1:0] cfg_waits;
	logic stretch;
	ebwsu_kind_e req_kind;

	// Picks the strobe to serve when the core drives more than one.
	function automatic ebwsu_kind_e ebwsu_pick(
		input logic mrd_n,
		input logic mwr_n,
		input logic int_io_read_n_n
	);
		if (!mrd_n) begin
			return K_MEM_RD;
		end else if (!mwr_n) begin
			return K_MEM_WR;
		end else if (!int_io_read_n_n) begin
			return K_IO_RD;
		end else begin
			return K_IO_WR;
		end
	endfunction

	always_comb begin
		any_req = !int_mem_read_n || !int_mem_write_n || !int_io_read_n || !int_io_write_n;
		ext_req = any_req && !cpu_on_chip;
		req_kind = ebwsu_pick(int_mem_read_n, int_mem_write_n, int_io_read_n);
		is_mem = (req_kind == K_MEM_RD) || (req_kind == K_MEM_WR);
		if (is_mem) begin
			if (link.upper_half) begin
				cfg_waits = system_control_1_wait[WSEL_UPPER] ? MEM_WAIT_SLOW
					: MEM_WAIT_FAST;
			end else begin
				cfg_waits = system_control_1_wait[WSEL_LOWER] ? MEM_WAIT_SLOW
					: MEM_WAIT_FAST;
			end
		end else begin
			cfg_waits = system_control_1_wait[WSEL_IO] ? IO_WAIT_EXTRA
				: IO_WAIT_BASE;
		end
		// A zero-wait memory cycle never looks at the wait request.
		stretch = ext_wait_request && !st_r.zero_wait;
	end

	always_comb begin
		st_nxt = st_r;
		st_nxt.clk_out = link.clk_phase;
		st_nxt.dbg_out = 1'h0;
		st_nxt.dbg_oe = 1'h0;
		if (link.sys_en) begin
			// The strap is read once, on the first system tick after release.
			if (st_r.strap_pending) begin
				st_nxt.strap_pending = 1'h0;
				st_nxt.debug_start = (mode_sel == DEBUG_MODE)
					&& (debug_serial_pin_in == ADAPTER_LEVEL);
			end
			case (st_r.state)
				ST_IDLE: begin
					if (ext_req) begin
						st_nxt.state = ST_STROBE;
						st_nxt.kind = req_kind;
						st_nxt.wait_cnt = cfg_waits;
						st_nxt.zero_wait = is_mem && (cfg_waits == MEM_WAIT_FAST);
						st_nxt.addr_out = cpu_addr[EXT_ADDR_W-1:0];
						st_nxt.pin17 = cs17_enable ? !link.rom_hit
							: cpu_addr[CS17_BIT];
						st_nxt.pin18 = cs18_enable ? !link.ramrom_hit
							: cpu_addr[CS18_BIT];
						st_nxt.mem_rd_n = !(req_kind == K_MEM_RD);
						st_nxt.mem_wr_n = !(req_kind == K_MEM_WR);
						st_nxt.io_rd_n = !(req_kind == K_IO_RD);
						st_nxt.io_wr_n = !(req_kind == K_IO_WR);
						st_nxt.cpu_wait = (cfg_waits != MEM_WAIT_FAST) || ext_wait_request
							&& !(is_mem && (cfg_waits == MEM_WAIT_FAST));
					end
				end
				ST_STROBE: begin
					if (st_r.wait_cnt != 2'h0) begin
						st_nxt.wait_cnt = st_r.wait_cnt - 2'h1;
						st_nxt.cpu_wait = 1'h1;
					end else if (stretch) begin
						st_nxt.state = ST_STRETCH;
						st_nxt.cpu_wait = 1'h1;
					end else begin
						st_nxt.state = ST_RELEASE;
						st_nxt.cpu_wait = 1'h0;
						st_nxt.mem_rd_n = STROBE_IDLE;
						st_nxt.mem_wr_n = STROBE_IDLE;
						st_nxt.io_rd_n = STROBE_IDLE;
						st_nxt.io_wr_n = STROBE_IDLE;
					end
				end
				ST_STRETCH: begin
					if (!stretch) begin
						st_nxt.state = ST_RELEASE;
						st_nxt.cpu_wait = 1'h0;
						st_nxt.mem_rd_n = STROBE_IDLE;
						st_nxt.mem_wr_n = STROBE_IDLE;
						st_nxt.io_rd_n = STROBE_IDLE;
						st_nxt.io_wr_n = STROBE_IDLE;
					end
				end
				ST_RELEASE: begin
					// Chip selects go inactive between cycles so a slow device
					// never sees two accesses merge into one.
					st_nxt.pin17 = cs17_enable ? STROBE_IDLE : st_r.pin17;
					st_nxt.pin18 = cs18_enable ? STROBE_IDLE : st_r.pin18;
					if (!any_req) begin
						st_nxt.state = ST_IDLE;
					end
				end
				default: begin
					st_nxt.state = ST_IDLE;
					st_nxt.cpu_wait = 1'h0;
					st_nxt.mem_rd_n = STROBE_IDLE;
					st_nxt.mem_wr_n = STROBE_IDLE;
					st_nxt.io_rd_n = STROBE_IDLE;
					st_nxt.io_wr_n = STROBE_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			st_r.state <= ST_IDLE;
			st_r.kind <= K_MEM_RD;
			st_r.wait_cnt <= 2'h0;
			st_r.zero_wait <= 1'h0;
			st_r.addr_out <= EXT_ADDR_RST;
			st_r.pin17 <= STROBE_IDLE;
			st_r.pin18 <= STROBE_IDLE;
			st_r.mem_rd_n <= STROBE_IDLE;
			st_r.mem_wr_n <= STROBE_IDLE;
			st_r.io_rd_n <= STROBE_IDLE;
			st_r.io_wr_n <= STROBE_IDLE;
			st_r.cpu_wait <= 1'h0;
			st_r.clk_out <= 1'h0;
			st_r.strap_pending <= 1'h1;
			st_r.debug_start <= 1'h0;
			st_r.dbg_out <= 1'h0;
			st_r.dbg_oe <= 1'h0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// The monitor itself lives elsewhere; this block only leaves the pin undriven.
	assign debug_serial_pin_out = st_r.dbg_out;
	assign debug_serial_pin_oe = st_r.dbg_oe;
	assign debug_monitor_start = st_r.debug_start;
	assign ext_addr = st_r.addr_out;
	assign rom_select_n = st_r.pin17;
	assign ram_rom_select_n = st_r.pin18;
	assign ext_mem_read_n = st_r.mem_rd_n;
	assign ext_mem_write_n = st_r.mem_wr_n;
	assign ext_io_read_n = st_r.io_rd_n;
	assign ext_io_write_n = st_r.io_wr_n;
	assign cpu_wait = st_r.cpu_wait;
	assign clk_out = st_r.clk_out;

endmodule

// [logic/ebwsu_pkg.sv]
package ebwsu_pkg;

	localparam int ADDR_W = 20;
	localparam int EXT_ADDR_W = 17;
	localparam int WAIT_W = 2;

	// Physical address windows of the two chip selects.
	localparam logic [19:0] ROM_CS_LO = 20'h0_0000;
	localparam logic [19:0] ROM_CS_HI = 20'h1_FFFF;
	localparam logic [19:0] RAMROM_CS_LO = 20'hE_0000;
	localparam logic [19:0] RAMROM_CS_HI = 20'hF_FDFF;
	localparam int HALF_BIT = 19;
	localparam int CS17_BIT = 17;
	localparam int CS18_BIT = 18;

	// Wait selection field: bit 0 for the lower half, bit 1 for the upper half.
	localparam int WSEL_LOWER = 0;
	localparam int WSEL_UPPER = 1;
	localparam int WSEL_IO = 0;
	localparam logic [1:0] MEM_WAIT_FAST = 2'h0;
	localparam logic [1:0] MEM_WAIT_SLOW = 2'h1;
	localparam logic [1:0] IO_WAIT_BASE = 2'h1;
	localparam logic [1:0] IO_WAIT_EXTRA = 2'h2;

	localparam logic [1:0] DEBUG_MODE = 2'h1;
	localparam logic ADAPTER_LEVEL = 1'h0;

	localparam logic [16:0] EXT_ADDR_RST = 17'h0_0000;
	localparam logic STROBE_IDLE = 1'h1;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_STROBE = 2'h1,
		ST_STRETCH = 2'h3,
		ST_RELEASE = 2'h2
	} ebwsu_state_e;

	typedef enum logic [1:0] {
		K_MEM_RD = 2'h0,
		K_MEM_WR = 2'h1,
		K_IO_RD = 2'h2,
		K_IO_WR = 2'h3
	} ebwsu_kind_e;

endpackage

// [logic/ebwsu_if.sv]
`timescale 1ns/1ps
interface ebwsu_if;
	logic sys_en;
	logic clk_phase;
	logic [19:0] addr;
	logic upper_half;
	logic rom_hit;
	logic ramrom_hit;

	modport div (output sys_en, output clk_phase);
	modport dec (input addr, output upper_half, output rom_hit, output ramrom_hit);
	modport core (
		input sys_en,
		input clk_phase,
		input upper_half,
		input rom_hit,
		input ramrom_hit,
		output addr
	);
endinterface

// [logic/ebwsu_clkdiv.sv]
`timescale 1ns/1ps
module ebwsu_clkdiv
	import ebwsu_pkg::*;
(
	input wire logic mclk,
	input wire logic arst_n,
	ebwsu_if.div bus
);
	typedef struct packed {
		logic phase;
	} ebwsu_div_s;

	ebwsu_div_s st_r;
	ebwsu_div_s st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.phase = ~st_r.phase;
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// One enable per two oscillator edges gives the halved system rate.
	assign bus.sys_en = st_r.phase;
	assign bus.clk_phase = st_r.phase;
endmodule

// [logic/ebwsu_decode.sv]
`timescale 1ns/1ps
module ebwsu_decode
	import ebwsu_pkg::*;
(
	ebwsu_if.dec bus
);
	always_comb begin
		bus.upper_half = bus.addr[HALF_BIT];
		bus.rom_hit = (bus.addr >= ROM_CS_LO) && (bus.addr <= ROM_CS_HI);
		bus.ramrom_hit = (bus.addr >= RAMROM_CS_LO) && (bus.addr <= RAMROM_CS_HI);
	end
endmodule

// [test/ebwsu_monitor.sv]
`timescale 1ns/1ps
module ebwsu_monitor
	import ebwsu_pkg::*;
(
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic [19:0] cpu_addr,
	input wire logic cpu_on_chip,
	input wire logic ext_wait_request,
	input wire logic [1:0] system_control_1_wait,
	input wire logic cs17_enable,
	input wire logic cs18_enable,
	input wire logic [1:0] mode_sel,
	input wire logic debug_serial_pin_in,
	input wire logic debug_monitor_start,
	input wire logic debug_serial_pin_out,
	input wire logic debug_serial_pin_oe,
	input wire logic [16:0] ext_addr,
	input wire logic rom_select_n,
	input wire logic ram_rom_select_n,
	input wire logic ext_mem_read_n,
	input wire logic ext_mem_write_n,
	input wire logic ext_io_read_n,
	input wire logic ext_io_write_n,
	input wire logic cpu_wait,
	input wire logic clk_out
);
	logic idle;
	assign idle = ext_mem_read_n & ext_mem_write_n & ext_io_read_n & ext_io_write_n;
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	sequence mrd_take;
		$fell(ext_mem_read_n);
	endsequence
	sequence mrd_short;
		!cpu_wait ##2 ext_mem_read_n;
	endsequence
	clk_half_a: assert property ($past(arst_n, 3) |-> clk_out != $past(clk_out))
		else $error("clock output stuck");
	on_chip_a: assert property (idle && cpu_on_chip |=> idle && !cpu_wait)
		else $error("on-chip access reached the pins");
	zero_wait_a: assert property (mrd_take and !system_control_1_wait[cpu_addr[19]] |-> mrd_short)
		else $error("zero-wait read length wrong");
	one_wait_a: assert property (mrd_take and system_control_1_wait[cpu_addr[19]] |-> !ext_mem_read_n[*3])
		else $error("one-wait read too short");
	io_wait_a: assert property ($fell(ext_io_write_n) && system_control_1_wait[0] |-> !ext_io_write_n[*6])
		else $error("two-wait io write too short");
	io_stretch_a: assert property ((!ext_io_read_n && ext_wait_request)[*2] |=> !ext_io_read_n)
		else $error("wait request not honoured");
	rom_sel_a: assert property (mrd_take and cs17_enable |-> rom_select_n == (cpu_addr > ROM_CS_HI))
		else $error("rom select wrong");
	ram_sel_a: assert property (mrd_take and cs18_enable |->
		ram_rom_select_n == !(cpu_addr >= RAMROM_CS_LO && cpu_addr <= RAMROM_CS_HI))
		else $error("ram rom select wrong");
	addr17_a: assert property (mrd_take and !cs17_enable |->
		rom_select_n == cpu_addr[17])
		else $error("pin 17 address bit wrong");
	addr18_a: assert property (mrd_take and !cs18_enable |->
		ram_rom_select_n == cpu_addr[18])
		else $error("pin 18 address bit wrong");
	pin_quiet_a: assert property (!debug_serial_pin_oe && !debug_serial_pin_out)
		else $error("debug pin driven");
	addr_out_a: assert property ($fell(idle) |-> ext_addr == cpu_addr[16:0])
		else $error("external address wrong");
	debug_go_a: assert property ($past(arst_n, 3) |->
		debug_monitor_start == (mode_sel == DEBUG_MODE && debug_serial_pin_in == ADAPTER_LEVEL))
		else $error("debug start wrong");
endmodule
bind ebwsu_top ebwsu_monitor mon (.*);

// [test/ebwsu_ext_dev.sv]
`timescale 1ns/1ps
module ebwsu_ext_dev (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic [3:0] strobe_n,
	input wire logic [3:0] stall,
	output logic ext_wait_request
);
	int cnt_r;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_r <= 0;
		end else begin
			cnt_r <= (&strobe_n) ? 0 : cnt_r + 1;
		end
	end
	// A slow device holds the request for stall ticks from the strobe edge.
	assign ext_wait_request = !(&strobe_n) && cnt_r < 2 * int'(stall);
endmodule

// [test/ebwsu_bench.sv]
`timescale 1ns/1ps
module ebwsu_bench;
	import ebwsu_pkg::*;
	typedef struct {logic [16:0] a; int lo; int hi;} ebwsu_exp_s;
	logic mclk = 1'h0;
	logic arst_n = 1'h0;
	logic [19:0] cpu_addr = 20'h0_0000;
	logic cpu_on_chip = 1'h0;
	logic [3:0] core_n = 4'hf;
	logic [1:0] wsel = 2'h0;
	logic [1:0] mode = 2'h1;
	logic [3:0] stall = 4'h0;
	logic [1:0] cs_en = 2'h3;
	logic dbg_pin = 1'h0;
	logic [31:0] rng = 32'h0000_298f;
	int num_errors = 0;
	int samples_checked = 0;
	int len = 0;
	ebwsu_exp_s q[$];
	logic req, dbg_go, cw, rs, rrs;
	logic [16:0] xa;
	logic [3:0] ext_n;
	ebwsu_top uut (.mclk(mclk), .arst_n(arst_n), .cpu_addr(cpu_addr), .cpu_on_chip(cpu_on_chip),
		.int_mem_read_n(core_n[0]), .int_mem_write_n(core_n[1]), .int_io_read_n(core_n[2]),
		.int_io_write_n(core_n[3]), .ext_wait_request(req), .system_control_1_wait(wsel),
		.cs17_enable(cs_en[0]), .cs18_enable(cs_en[1]), .mode_sel(mode),
		.debug_serial_pin_in(dbg_pin),
		.debug_serial_pin_out(), .debug_serial_pin_oe(), .debug_monitor_start(dbg_go),
		.ext_addr(xa), .rom_select_n(rs), .ram_rom_select_n(rrs), .ext_mem_read_n(ext_n[0]),
		.ext_mem_write_n(ext_n[1]), .ext_io_read_n(ext_n[2]), .ext_io_write_n(ext_n[3]),
		.cpu_wait(cw), .clk_out());
	ebwsu_ext_dev dev (.mclk(mclk), .arst_n(arst_n), .strobe_n(ext_n), .stall(stall),
		.ext_wait_request(req));
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] t;
		t = v ^ (v << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	task wrap_up;
		if (num_errors == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task chk_eq(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task chk_len(input ebwsu_exp_s e, input logic [16:0] a, input int n);
		samples_checked++;
		if (a !== e.a || n < e.lo || n > e.hi) begin
			num_errors++;
			$display("unexpected at %0t: got %h/%h want %h/%h", $time, a, n, e.a, e.lo);
		end
	endtask
	task acc(input int k, input logic oc, input logic [1:0] ws, input logic [3:0] st);
		int w;
		int e;
		@(posedge mclk);
		#2;
		rng = xs(rng);
		cpu_addr = rng[19:0];
		cs_en = rng[21:20];
		cpu_on_chip = oc;
		wsel = ws;
		stall = st;
		w = k < 2 ? int'(ws[cpu_addr[19]]) : 1 + int'(ws[0]);
		// The device holds its request for st ticks, so it only stretches past w when st > w.
		e = (k < 2 && w == 0) ? 2 : 2 * (1 + (int'(st) > w ? int'(st) : w));
		if (!oc)
			q.push_back('{cpu_addr[16:0], e, e});
		core_n[k] = 1'b0;
		// The core lets go once 4 mclk cycles have passed, the strobe has ended and wait is low, or at the latest after 60 mclk cycles.
		for (int n = 0; n < 60 && (ext_n != 4'hf || cw || n < 4); n++) begin
			@(posedge mclk);
			#2;
		end
		core_n = 4'hf;
		repeat (4) @(posedge mclk);
	endtask
	always begin
		@(posedge mclk);
		#1;
		if (!arst_n)
			len = 0;
		else if (ext_n != 4'hf)
			len++;
		else if (len > 0) begin
			if (q.size() == 0)
				chk_eq(1'b0, 1'b1);
			else
				chk_len(q.pop_front(), xa, len);
			len = 0;
		end
	end
	initial forever #10 mclk = ~mclk;
	initial begin
		#200000;
		num_errors++;
		wrap_up;
	end
	initial begin
		repeat (16) @(posedge mclk);
		#2 arst_n = 1'b1;
		repeat (4) @(posedge mclk);
		#1 chk_eq(dbg_go, 1'b1);
		for (int i = 0; i < 16; i++)
			acc(i % 4, 1'b0, i[3:2], 4'h0);
		acc(0, 1'b1, 2'h0, 4'h0);
		acc(0, 1'b0, 2'h0, 4'h3);
		acc(2, 1'b0, 2'h0, 4'h3);
		acc(3, 1'b0, 2'h1, 4'h4);
		// Cut an I/O read in mid-cycle to see reset end it at once.
		@(posedge mclk);
		#2 core_n[2] = 1'b0;
		stall = 4'h8;
		repeat (4) @(posedge mclk);
		#2 chk_eq(!ext_n[2] && cw, 1'b1);
		arst_n = 1'b0;
		mode = 2'h2;
		core_n = 4'hf;
		#5 chk_eq(ext_n == 4'hf && !cw, 1'b1);
		repeat (3) @(posedge mclk);
		#2 arst_n = 1'b1;
		repeat (4) @(posedge mclk);
		#1 chk_eq(dbg_go, 1'b0);
		acc(1, 1'b0, 2'h3, 4'h0);
		repeat (4) @(posedge mclk);
		chk_eq(q.size() == 0, 1'b1);
		#2 arst_n = 1'b0;
		mode = 2'h1;
		dbg_pin = 1'b1;
		repeat (3) @(posedge mclk);
		#2 arst_n = 1'b1;
		repeat (4) @(posedge mclk);
		#1 chk_eq(dbg_go, 1'b0);
		wrap_up;
	end
endmodule
